// ==== hw/etp_timer.sv ====
/*
  8-bit timer/counter with two compare units and fast PWM outputs,
  reached over APB.
  Assumes the external count pin and APB inputs are synchronous to clock.
*/
// Our own choices: the APB slave port and the placing of the registers.
// Operation
// - Count is 8 bits; 0x00 is BOTTOM, 0xFF is MAX.
// - TOP is MAX or compare value A, chosen by waveform mode.
// - Timer runs only while its power-off bit is written zero.
// - Count and both compare registers are 8 bits wide.
// - Three flags visible in flag register, each masked by mask register.
// - Tick from prescaler or external pin; select also picks the edge.
// - Clock select zero means no ticks and a frozen count.
// - Three-bit clock select field sits in control register B.
// - Buffered compare values compared continuously, feeding wave generators.
// - Compare match on A or B sets that unit's flag.
// - In fast PWM the overflow flag sets each time count reaches TOP.
// - Mode two gives non-inverted PWM, mode three inverted PWM.
// - Mode one toggles output A only when mode bit 2 set.
// - Waveform reaches pin only while its direction is output.
// - Output set or cleared at match, opposite at TOP-to-BOTTOM wrap.
// - Prescale 1, 8, 64, 256, 1024; fast PWM period 256 ticks when TOP is MAX.
// - Compare A at BOTTOM gives a narrow spike every MAX+1 ticks.
// - Compare A at MAX gives a constant level by polarity.
// - Toggle mode gives 50% square wave, fastest at half clock.
module etp_timer (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                reset_n,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  // Pins
  input  wire logic                extCount,
  output etp_pkg::etp_wave_t       wave,
  // Interrupt requests, one per source after masking
  output logic [2:0]               irqReq
);
  import etp_pkg::*;

  // ==========================================================================
  // Registers
  logic [7:0] ctrlA;
  logic [7:0] ctrlB;
  logic [7:0] countValue;
  logic [7:0] compareValueA;
  logic [7:0] compareValueB;
  logic [7:0] bufA;
  logic [7:0] bufB;
  logic [2:0] flags;
  logic [2:0] mask;
  logic       powerOff;
  logic [1:0] pinDir;
  logic [9:0] prescale;
  logic       extPrev;
  logic       waveA;
  logic       waveB;

  // ==========================================================================
  // Decode
  logic       wrEn;
  logic       rdEn;
  logic [2:0] waveMode;
  logic [2:0] clockSel;
  logic [1:0] comA;
  logic [1:0] comB;
  logic       fastPwm;
  logic       topIsA;
  logic [7:0] topValue;
  logic       tick;
  logic       atTop;
  logic       matchA;
  logic       matchB;
  logic [2:0] setFlags;
  logic       wrCount;
  logic       wrFlags;
  logic       drvA;
  logic       drvB;

  // ==========================================================================
  // Decode helpers
  // One prescaler tap: true once per period of its masked low bits.
  function automatic logic tapHit(input logic [9:0] count,
                                  input logic [9:0] tapMask);
    return (count & tapMask) == tapMask;
  endfunction

  // A unit drives its pin only for a compare output mode that means
  // something in the current waveform mode. Mode one in fast PWM toggles
  // unit A only, and only with waveform mode bit 2; otherwise the pin is
  // left to ordinary port use.
  function automatic logic unitDrives(input logic [1:0] com,
                                      input logic       fast,
                                      input logic       modeBit2,
                                      input logic       isUnitA);
    if (com == ETP_COM_OFF) begin
      return 1'b0;
    end
    if (fast && (com == ETP_COM_TOGGLE)) begin
      return isUnitA && modeBit2;
    end
    return 1'b1;
  endfunction

  assign wrEn     = psel && penable && pwrite;
  assign rdEn     = psel && !penable && !pwrite;
  assign waveMode = {ctrlB[ETP_CTRLB_MODE2], ctrlA[ETP_CTRLA_MODE_LO +: 2]};
  assign clockSel = ctrlB[ETP_CTRLB_CS_LO +: 3];
  assign comA     = ctrlA[ETP_CTRLA_COMA_LO +: 2];
  assign comB     = ctrlA[ETP_CTRLA_COMB_LO +: 2];
  assign fastPwm  = (waveMode == ETP_WM_FAST) || (waveMode == ETP_WM_FASTTOP);
  assign topIsA   = (waveMode == ETP_WM_FASTTOP) || (waveMode == ETP_WM_CTC);
  assign topValue = topIsA ? bufA : ETP_MAX;
  assign atTop    = (countValue == topValue);
  // Compare against the buffered copies so a write mid-period is glitch free.
  assign matchA   = tick && (countValue == bufA);
  assign matchB   = tick && (countValue == bufB);
  // Strobes for the two registers that hardware updates as well.
  assign wrCount  = wrEn && (paddr == ETP_OFF_COUNT);
  assign wrFlags  = wrEn && (paddr == ETP_OFF_FLAGS);
  assign drvA     = unitDrives(comA, fastPwm, waveMode[2], 1'b1);
  assign drvB     = unitDrives(comB, fastPwm, waveMode[2], 1'b0);

  // ==========================================================================
  // Clock select and prescaler
  // The prescaler stops with the module so it restarts from zero.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      prescale <= 10'h000;
    end else begin
      prescale <= powerOff ? 10'h000 : prescale + 10'h001;
    end
  end

  // Previous pin sample; it resets to the pin's idle low level, so the
  // release of reset shows no false edge.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      extPrev <= 1'b0;
    end else begin
      extPrev <= extCount;
    end
  end

  always_comb begin
    unique case (etp_cs_t'(clockSel))
      ETP_CS_NONE:    tick = 1'b0;
      ETP_CS_DIV1:    tick = 1'b1;
      ETP_CS_DIV8:    tick = tapHit(prescale, ETP_DIV8_MASK);
      ETP_CS_DIV64:   tick = tapHit(prescale, ETP_DIV64_MASK);
      ETP_CS_DIV256:  tick = tapHit(prescale, ETP_DIV256_MASK);
      ETP_CS_DIV1024: tick = tapHit(prescale, ETP_DIV1024_MASK);
      ETP_CS_EXTFALL: tick = extPrev && !extCount;
      ETP_CS_EXTRISE: tick = !extPrev && extCount;
    endcase
    if (powerOff) begin
      tick = 1'b0;
    end
  end

  // ==========================================================================
  // Counter
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      countValue <= ETP_ZERO8;
    end else if (wrCount) begin
      // A software write wins over a tick in the same cycle.
      countValue <= pwdata[7:0];
    end else if (tick) begin
      countValue <= atTop ? ETP_BOTTOM : countValue + 8'h01;
    end
  end

  // Compare buffers load at TOP in PWM modes, at once otherwise.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      bufA <= ETP_ZERO8;
      bufB <= ETP_ZERO8;
    end else if (!fastPwm || (tick && atTop)) begin
      bufA <= compareValueA;
      bufB <= compareValueB;
    end
  end

  // ==========================================================================
  // Flags: hardware set wins over software clear.
  always_comb begin
    setFlags                = 3'h0;
    setFlags[ETP_FLAG_CMPA] = matchA;
    setFlags[ETP_FLAG_CMPB] = matchB;
    setFlags[ETP_FLAG_OVF]  = tick &&
        (fastPwm ? atTop : (countValue == ETP_MAX));
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      flags <= 3'h0;
    end else begin
      // Writing one clears a flag.
      flags <= (wrFlags ?
                (flags & ~pwdata[2:0]) : flags) | setFlags;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      irqReq <= 3'h0;
    end else begin
      irqReq <= flags & mask;
    end
  end

  // ==========================================================================
  // Waveform generators
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      waveA <= 1'b0;
    end else if (fastPwm) begin
      if (comA == ETP_COM_TOGGLE) begin
        if (waveMode[2] && matchA) begin
          waveA <= !waveA;
        end
      end else if (comA != ETP_COM_OFF) begin
        // Match has priority, so compare A at BOTTOM leaves a one-tick
        // spike and compare A at MAX holds the level.
        if (matchA) begin
          waveA <= (comA == ETP_COM_INV);
        end else if (tick && atTop) begin
          waveA <= (comA == ETP_COM_NONINV);
        end
      end
    end else if (matchA) begin
      unique case (comA)
        ETP_COM_OFF:    waveA <= waveA;
        ETP_COM_TOGGLE: waveA <= !waveA;
        ETP_COM_NONINV: waveA <= 1'b0;
        ETP_COM_INV:    waveA <= 1'b1;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      waveB <= 1'b0;
    end else if (fastPwm) begin
      // Output B has no toggle option in fast PWM.
      if (comB[1]) begin
        if (matchB) begin
          waveB <= (comB == ETP_COM_INV);
        end else if (tick && atTop) begin
          waveB <= (comB == ETP_COM_NONINV);
        end
      end
    end else if (matchB) begin
      unique case (comB)
        ETP_COM_OFF:    waveB <= waveB;
        ETP_COM_TOGGLE: waveB <= !waveB;
        ETP_COM_NONINV: waveB <= 1'b0;
        ETP_COM_INV:    waveB <= 1'b1;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wave <= '0;
    end else begin
      wave.outA <= waveA;
      wave.outB <= waveB;
      // Pin drives only when connected and its direction is output.
      wave.enA  <= pinDir[0] && drvA;
      wave.enB  <= pinDir[1] && drvB;
    end
  end

  // ==========================================================================
  // APB register writes
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ctrlA <= ETP_ZERO8;
    end else if (wrEn && (paddr == ETP_OFF_CTRL_A)) begin
      ctrlA <= pwdata[7:0];
    end
  end

  // Only clock select and waveform mode bit 2 exist; the rest read zero.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ctrlB <= ETP_ZERO8;
    end else if (wrEn && (paddr == ETP_OFF_CTRL_B)) begin
      ctrlB <= {4'h0, pwdata[3:0]};
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      compareValueA <= ETP_ZERO8;
      compareValueB <= ETP_ZERO8;
    end else if (wrEn) begin
      if (paddr == ETP_OFF_CMP_A) begin
        compareValueA <= pwdata[7:0];
      end
      if (paddr == ETP_OFF_CMP_B) begin
        compareValueB <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mask <= 3'h0;
    end else if (wrEn && (paddr == ETP_OFF_MASK)) begin
      mask <= pwdata[2:0];
    end
  end

  // The module wakes up powered off, so no tick reaches the counter until
  // software has cleared this bit.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      powerOff <= ETP_POWER_OFF_RST;
    end else if (wrEn && (paddr == ETP_OFF_POWER)) begin
      powerOff <= pwdata[0];
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pinDir <= 2'h0;
    end else if (wrEn && (paddr == ETP_OFF_PINCTL)) begin
      pinDir <= pwdata[1:0];
    end
  end

  // ==========================================================================
  // APB read data and ready; reads are captured in the setup cycle.
  function automatic logic mapped(input logic [7:0] a);
    return a == ETP_OFF_CTRL_A || a == ETP_OFF_CTRL_B ||
           a == ETP_OFF_COUNT  || a == ETP_OFF_CMP_A  ||
           a == ETP_OFF_CMP_B  || a == ETP_OFF_FLAGS  ||
           a == ETP_OFF_MASK   || a == ETP_OFF_POWER  ||
           a == ETP_OFF_PINCTL;
  endfunction

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (rdEn) begin
      unique case (paddr)
        ETP_OFF_CTRL_A: prdata <= {24'h0, ctrlA};
        ETP_OFF_CTRL_B: prdata <= {24'h0, ctrlB};
        ETP_OFF_COUNT:  prdata <= {24'h0, countValue};
        ETP_OFF_CMP_A:  prdata <= {24'h0, compareValueA};
        ETP_OFF_CMP_B:  prdata <= {24'h0, compareValueB};
        ETP_OFF_FLAGS:  prdata <= {29'h0, flags};
        ETP_OFF_MASK:   prdata <= {29'h0, mask};
        ETP_OFF_POWER:  prdata <= {31'h0, powerOff};
        ETP_OFF_PINCTL: prdata <= {30'h0, pinDir};
        default:        prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped(paddr);
    end
  end

endmodule // etp_timer

// ==== hw/etp_pkg.sv ====
/*
  Package for the 8-bit timer with PWM: register offsets, field layout,
  reset values and shared types.
  Assumes an APB slave with 32-bit data, one aligned word per register.
*/
package etp_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] ETP_OFF_CTRL_A   = 8'h00;
  localparam logic [7:0] ETP_OFF_CTRL_B   = 8'h04;
  localparam logic [7:0] ETP_OFF_COUNT    = 8'h08;
  localparam logic [7:0] ETP_OFF_CMP_A    = 8'h0c;
  localparam logic [7:0] ETP_OFF_CMP_B    = 8'h10;
  localparam logic [7:0] ETP_OFF_FLAGS    = 8'h14;
  localparam logic [7:0] ETP_OFF_MASK     = 8'h18;
  localparam logic [7:0] ETP_OFF_POWER    = 8'h1c;
  localparam logic [7:0] ETP_OFF_PINCTL   = 8'h20;

  // ==========================================================================
  // Counter landmarks
  localparam logic [7:0] ETP_BOTTOM       = 8'h00;
  localparam logic [7:0] ETP_MAX          = 8'hff;

  // ==========================================================================
  // Field positions
  localparam int ETP_CTRLA_MODE_LO = 0;
  localparam int ETP_CTRLA_COMB_LO = 4;
  localparam int ETP_CTRLA_COMA_LO = 6;
  localparam int ETP_CTRLB_CS_LO   = 0;
  localparam int ETP_CTRLB_MODE2   = 3;
  localparam int ETP_FLAG_OVF      = 0;
  localparam int ETP_FLAG_CMPA     = 1;
  localparam int ETP_FLAG_CMPB     = 2;

  // ==========================================================================
  // Reset values
  localparam logic       ETP_POWER_OFF_RST = 1'b1;
  localparam logic [7:0] ETP_ZERO8         = 8'h00;

  // ==========================================================================
  // Clock select codes and prescale divisors
  typedef enum logic [2:0] {
    ETP_CS_NONE = 3'h0, ETP_CS_DIV1 = 3'h1, ETP_CS_DIV8 = 3'h2,
    ETP_CS_DIV64 = 3'h3, ETP_CS_DIV256 = 3'h4, ETP_CS_DIV1024 = 3'h5,
    ETP_CS_EXTFALL = 3'h6, ETP_CS_EXTRISE = 3'h7
  } etp_cs_t;

  localparam logic [9:0] ETP_DIV8_MASK    = 10'h007;
  localparam logic [9:0] ETP_DIV64_MASK   = 10'h03f;
  localparam logic [9:0] ETP_DIV256_MASK  = 10'h0ff;
  localparam logic [9:0] ETP_DIV1024_MASK = 10'h3ff;

  // Compare output mode codes.
  localparam logic [1:0] ETP_COM_OFF    = 2'h0;
  localparam logic [1:0] ETP_COM_TOGGLE = 2'h1;
  localparam logic [1:0] ETP_COM_NONINV = 2'h2;
  localparam logic [1:0] ETP_COM_INV    = 2'h3;

  // Waveform mode, 3 bits: {bit2, bit1, bit0}.
  localparam logic [2:0] ETP_WM_NORMAL  = 3'h0;
  localparam logic [2:0] ETP_WM_FAST    = 3'h3;
  localparam logic [2:0] ETP_WM_CTC     = 3'h2;
  localparam logic [2:0] ETP_WM_FASTTOP = 3'h7;

  // Packed waveform pin group.
  typedef struct packed {
    logic outA;
    logic outB;
    logic enA;
    logic enB;
  } etp_wave_t;

endpackage : etp_pkg

// ==== verification/etp_timer_monitor.sv ====
/*
  Checker for the timer's APB and pin ports.
  Assumes it is bound to every etp_timer instance.
*/
module etp_timer_monitor
  import etp_pkg::*;
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        reset_n,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Pins
  input wire logic        extCount,
  input wire etp_wave_t   wave,
  input wire logic [2:0]  irqReq
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Port checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  chk_setup_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_unmapped_err: assert property (pready && paddr > ETP_OFF_PINCTL
    |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (pready && paddr <= ETP_OFF_PINCTL
    && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  chk_rdata_hold: assert property (!(psel && !penable && !pwrite)
    |=> $stable(prdata))
    else $error("read data moved");
  chk_mask_off: assert property (pready && pwrite &&
    paddr == ETP_OFF_MASK && pwdata[2:0] == 3'h0 |-> ##2 irqReq == 3'h0)
    else $error("masked request still raised");
  chk_pin_off: assert property (pready && pwrite &&
    paddr == ETP_OFF_PINCTL && pwdata[1:0] == 2'h0
    |-> ##[1:3] !wave.enA && !wave.enB)
    else $error("pin driven while input");
endmodule // etp_timer_monitor

bind etp_timer etp_timer_monitor u_mon (.clock, .reset_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .extCount, .wave,
  .irqReq);

// ==== verification/etp_pin_model.sv ====
/*
  Pin partner: pulses the external count pin and times output A.
  Assumes a pull-down on output A, so an undriven pin reads low.
*/
module etp_pin_model
  import etp_pkg::*;
(
  // Clock
  input wire logic        clock,
  // Pins
  input wire etp_wave_t   wave,
  output logic            extCount,
  // Control and results
  input wire logic        go,
  input wire logic [7:0]  burst,
  output logic [15:0]     period,
  output logic [15:0]     highTime
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  left = 8'h0;
  logic [1:0]  ph = 2'h0;
  logic [15:0] cnt = 16'h0;
  logic        pin;
  logic        last = 1'b0;
  initial extCount = 1'b0;
  initial period = 16'h0;
  initial highTime = 16'h0;
  // ==========================================================================
  // Count pin stays low outside a burst; each pulse is 2 low, 2 high.
  always @(posedge clock) begin
    if (go) left <= burst;
    else if (left != 8'h0) begin
      ph <= ph + 2'h1;
      if (ph == 2'h3) left <= left - 8'h1;
    end
    extCount <= (left != 8'h0) && ph[1];
  end
  // ==========================================================================
  // Output timing, measured in clock cycles between edges.
  assign pin = wave.enA & wave.outA;
  always @(posedge clock) begin
    last <= pin;
    cnt <= (pin && !last) ? 16'h1 : cnt + 16'h1;
    if (pin && !last) period <= cnt;
    if (!pin && last) highTime <= cnt;
  end
endmodule // etp_pin_model

// ==== verification/tb.sv ====
/*
  Self-checking bench for the timer, driven over APB.
  Assumes the design and pin model files are compiled first.
*/
module tb;
  import etp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, lastErr, extCount, go = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, r, q;
  logic [2:0]  irqReq;
  logic [15:0] period, highTime;
  etp_wave_t   wave;
  int errors = 0, checkCount = 0;

  etp_timer DUT (.clock, .reset_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .extCount, .wave, .irqReq);
  etp_pin_model u_pins (.clock, .wave, .extCount, .go, .burst(8'd10),
    .period, .highTime);

  initial forever #50 clock = ~clock;

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    r = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("read", r, exp);
  endtask

  task automatic wait_c(int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    wait_c(50000);
    errors++;
    wrap_up;
  end

  initial begin
    wait_c(8);
    reset_n <= 1'b1;
    rd(ETP_OFF_POWER, 32'h1);
    rd(ETP_OFF_COUNT, 32'h0);
    apb(1'b1, ETP_OFF_CMP_B, 32'h1ff);
    rd(ETP_OFF_CMP_B, 32'hff);
    rd(8'h40, 32'h0);
    chk("refused", {31'h0, lastErr}, 32'h1);
    apb(1'b1, ETP_OFF_CTRL_B, 32'h1);
    apb(1'b1, ETP_OFF_COUNT, 32'h10);
    wait_c(20);
    rd(ETP_OFF_COUNT, 32'h10);
    apb(1'b1, ETP_OFF_CTRL_B, 32'h0);
    apb(1'b1, ETP_OFF_POWER, 32'h0);
    wait_c(20);
    rd(ETP_OFF_COUNT, 32'h10);
    apb(1'b1, ETP_OFF_CTRL_B, 32'h1);
    apb(1'b0, ETP_OFF_COUNT, 32'h0);
    q = r;
    apb(1'b0, ETP_OFF_COUNT, 32'h0);
    chk("step", {24'h0, r[7:0] - q[7:0]}, 32'h3);
    for (int cs = 6; cs <= 7; cs++) begin
      apb(1'b1, ETP_OFF_CTRL_B, 32'h0);
      apb(1'b1, ETP_OFF_COUNT, 32'h0);
      apb(1'b1, ETP_OFF_CTRL_B, cs);
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      wait_c(60);
      rd(ETP_OFF_COUNT, 32'd10);
    end
    apb(1'b1, ETP_OFF_PINCTL, 32'h3);
    apb(1'b1, ETP_OFF_CMP_A, 32'h40);
    for (int c = 2; c <= 3; c++) begin
      apb(1'b1, ETP_OFF_CTRL_A, (c << 6) | (c << 4) | 3);
      apb(1'b1, ETP_OFF_CTRL_B, 32'h1);
      wait_c(800);
      chk("period", period, 16'd256);
      chk("high", highTime, c == 2 ? 16'd65 : 16'd191);
      chk("outB", wave.outB, c == 3);
      chk("enB", wave.enB, 1'b1);
    end
    apb(1'b1, ETP_OFF_CTRL_B, 32'h2);
    wait_c(6000);
    chk("period8", period, 16'd2048);
    rd(ETP_OFF_FLAGS, 32'h7);
    apb(1'b1, ETP_OFF_MASK, 32'h7);
    wait_c(3);
    chk("irq", irqReq, 3'h7);
    apb(1'b1, ETP_OFF_CTRL_B, 32'h0);
    apb(1'b1, ETP_OFF_FLAGS, 32'h7);
    rd(ETP_OFF_FLAGS, 32'h0);
    chk("irq", irqReq, 3'h0);
    apb(1'b1, ETP_OFF_CMP_A, 32'h0);
    apb(1'b1, ETP_OFF_CMP_B, 32'h0);
    apb(1'b1, ETP_OFF_CTRL_A, 32'h53);
    apb(1'b1, ETP_OFF_CTRL_B, 32'h9);
    wait_c(400);
    chk("toggle", period, 16'd2);
    chk("half", highTime, 16'd1);
    chk("enB", wave.enB, 1'b0);
    chk("holdB", wave.outB, 1'b1);
    @(posedge clock);
    chk("holdB", wave.outB, 1'b1);
    apb(1'b1, ETP_OFF_MASK, 32'h0);
    apb(1'b1, ETP_OFF_PINCTL, 32'h0);
    wait_c(5);
    chk("enA", wave.enA, 1'b0);
    wrap_up;
  end
endmodule // tb
